// [include/dbcl_pkg.sv]
package dbcl_pkg;
	localparam int NUM_BANKS = 8;
	localparam int BANK_W = 3;
	localparam int TMR_W = 12;
	localparam int CLK_PERIOD_PS = 40000;
	localparam int PER_BANK_REFRESH_NS = 90;
	localparam int ALL_BANK_REFRESH_NS = 130;
	localparam int MODE_READ_BUSY_NS = 80;
	localparam int MODE_WRITE_BUSY_NS = 50;
	localparam int PRECHARGE_PERIOD_NS = 18;
	localparam int ACTIVATE_TO_COLUMN_NS = 18;
	localparam int POWER_DOWN_EXIT_NS = 8;
	localparam int SELF_REFRESH_EXIT_NS = 140;
	localparam int AUTO_INIT_NS = 10000;
	localparam logic [7:0] RESET_MODE_ADDR = 8'h3F;
	localparam logic [3:0] BURST_EDGES = 4'h4;

	function automatic int cyc_min(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam logic [TMR_W-1:0] RFCPB_CYC = TMR_W'(cyc_min(PER_BANK_REFRESH_NS));
	localparam logic [TMR_W-1:0] RFCAB_CYC = TMR_W'(cyc_min(ALL_BANK_REFRESH_NS));
	localparam logic [TMR_W-1:0] MRD_CYC = TMR_W'(cyc_min(MODE_READ_BUSY_NS));
	localparam logic [TMR_W-1:0] MWR_CYC = TMR_W'(cyc_min(MODE_WRITE_BUSY_NS));
	localparam logic [TMR_W-1:0] RP_CYC = TMR_W'(cyc_min(PRECHARGE_PERIOD_NS));
	localparam logic [TMR_W-1:0] RCD_CYC = TMR_W'(cyc_min(ACTIVATE_TO_COLUMN_NS));
	localparam logic [TMR_W-1:0] INIT_CYC = TMR_W'(cyc_min(AUTO_INIT_NS));
	localparam logic [TMR_W-1:0] EXIT_CYC = TMR_W'((SELF_REFRESH_EXIT_NS > POWER_DOWN_EXIT_NS) ?
		cyc_min(SELF_REFRESH_EXIT_NS) : cyc_min(POWER_DOWN_EXIT_NS));
	localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

	typedef enum logic [3:0] {
		CMD_NOP           = 4'h0,
		CMD_ACTIVATE      = 4'h1,
		CMD_READ          = 4'h2,
		CMD_WRITE         = 4'h3,
		CMD_PRECHARGE     = 4'h4,
		CMD_PRECHARGE_ALL = 4'h5,
		CMD_REFRESH_BANK  = 4'h6,
		CMD_REFRESH_ALL   = 4'h7,
		CMD_MODE_READ     = 4'h8,
		CMD_MODE_WRITE    = 4'h9,
		CMD_BURST_STOP    = 4'hA
	} dbcl_cmd_t;

	typedef enum logic [3:0] {
		BS_IDLE           = 4'h0,
		BS_ACTIVATING     = 4'h1,
		BS_ACTIVE         = 4'h2,
		BS_READING        = 4'h3,
		BS_WRITING        = 4'h4,
		BS_READ_AUTO      = 4'h5,
		BS_WRITE_AUTO     = 4'h6,
		BS_PRECHARGING    = 4'h7,
		BS_REFRESHING     = 4'h8,
		BS_IDLE_MODE_RD   = 4'h9,
		BS_ACTIVE_MODE_RD = 4'hA
	} dbcl_bank_state_t;

	typedef enum logic [2:0] {
		BO_ACTIVATE  = 3'h0,
		BO_READ      = 3'h1,
		BO_WRITE     = 3'h2,
		BO_PRECHARGE = 3'h3,
		BO_REFRESH   = 3'h4,
		BO_MODE_READ = 3'h5,
		BO_STOP      = 3'h6
	} dbcl_bank_op_t;

	typedef enum logic [2:0] {
		DS_POWER_ON       = 3'h0,
		DS_RESETTING      = 3'h1,
		DS_RESET_MODE_RD  = 3'h2,
		DS_READY          = 3'h3,
		DS_REFRESH_ALL    = 3'h4,
		DS_MODE_WRITING   = 3'h5,
		DS_PRECHARGE_ALL  = 3'h6
	} dbcl_dev_state_t;

	function automatic logic is_plain_burst(input dbcl_bank_state_t s);
		return s == BS_READING || s == BS_WRITING;
	endfunction

	function automatic logic is_burst(input dbcl_bank_state_t s);
		return is_plain_burst(s) || s == BS_READ_AUTO || s == BS_WRITE_AUTO;
	endfunction
endpackage

// [include/dbcl_bank_if.sv]
`timescale 1ns/1ps
interface dbcl_bank_if import dbcl_pkg::*; ();
	logic             opValid;
	dbcl_bank_op_t    op;
	logic             autoPrecharge;
	logic             linkTick;
	dbcl_bank_state_t state;

	modport ctrl(output opValid, output op, output autoPrecharge, output linkTick, input state);
	modport bank(input opValid, input op, input autoPrecharge, input linkTick, output state);
endinterface

// [hw/dbcl_bank.sv]
`timescale 1ns/1ps
module dbcl_bank import dbcl_pkg::*; (
	input wire logic  clk_sys,
	input wire logic  sys_rst,
	dbcl_bank_if.bank bankPort
);
	dbcl_bank_state_t   state_reg;
	logic [TMR_W-1:0]   timer_reg;
	logic [3:0]         burst_reg;
	logic               burstEnd;

	assign bankPort.state = state_reg;
	// burst length counts link edges, not system cycles
	assign burstEnd = bankPort.linkTick && burst_reg == 4'h1;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			burst_reg <= 4'h0;
		end else if (bankPort.opValid && (bankPort.op == BO_READ || bankPort.op == BO_WRITE)) begin
			burst_reg <= BURST_EDGES;
		end else if (bankPort.opValid && bankPort.op == BO_STOP) begin
			burst_reg <= 4'h0;
		end else if (bankPort.linkTick && burst_reg != 4'h0) begin
			burst_reg <= burst_reg - 4'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_reg <= BS_IDLE;
			timer_reg <= '0;
		end else if (bankPort.opValid) begin
			case (bankPort.op)
				BO_ACTIVATE: begin
					state_reg <= BS_ACTIVATING;
					timer_reg <= RCD_CYC - TMR_ONE;
				end
				BO_READ: begin
					state_reg <= bankPort.autoPrecharge ? BS_READ_AUTO : BS_READING;
				end
				BO_WRITE: begin
					state_reg <= bankPort.autoPrecharge ? BS_WRITE_AUTO : BS_WRITING;
				end
				BO_PRECHARGE: begin
					state_reg <= BS_PRECHARGING;
					timer_reg <= RP_CYC - TMR_ONE;
				end
				BO_REFRESH: begin
					state_reg <= BS_REFRESHING;
					timer_reg <= RFCPB_CYC - TMR_ONE;
				end
				BO_MODE_READ: begin
					// an activating bank will be active once the read finishes
					state_reg <= (state_reg == BS_ACTIVE || state_reg == BS_ACTIVATING) ?
						BS_ACTIVE_MODE_RD : BS_IDLE_MODE_RD;
					timer_reg <= MRD_CYC - TMR_ONE;
				end
				BO_STOP: begin
					if (is_plain_burst(state_reg))
						state_reg <= BS_ACTIVE;
				end
				default: state_reg <= state_reg;
			endcase
		end else if (burstEnd && is_burst(state_reg)) begin
			if (is_plain_burst(state_reg)) begin
				state_reg <= BS_ACTIVE;
			end else begin
				state_reg <= BS_PRECHARGING;
				timer_reg <= RP_CYC - TMR_ONE;
			end
		end else if (timer_reg != '0) begin
			timer_reg <= timer_reg - TMR_ONE;
		end else begin
			case (state_reg)
				BS_ACTIVATING:     state_reg <= BS_ACTIVE;
				BS_PRECHARGING:    state_reg <= BS_IDLE;
				BS_REFRESHING:     state_reg <= BS_IDLE;
				BS_IDLE_MODE_RD:   state_reg <= BS_IDLE;
				BS_ACTIVE_MODE_RD: state_reg <= BS_ACTIVE;
				default:           state_reg <= state_reg;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_bank_refresh_span: assert property (
		$rose(state_reg == BS_REFRESHING) |-> (state_reg == BS_REFRESHING) [*3] ##1 state_reg == BS_IDLE)
		else $error("bank refresh did not last its refresh time");
	a_mode_read_return: assert property (
		$rose(state_reg == BS_ACTIVE_MODE_RD) |-> (state_reg == BS_ACTIVE_MODE_RD) [*2] ##1 state_reg == BS_ACTIVE)
		else $error("mode read did not return the bank to active");
	a_stop_to_active: assert property (
		bankPort.opValid && bankPort.op == BO_STOP && is_plain_burst(state_reg) |=> state_reg == BS_ACTIVE)
		else $error("terminate did not return bank to active");
	a_idle_precharge_wait: assert property (
		bankPort.opValid && bankPort.op == BO_PRECHARGE && state_reg == BS_IDLE
		|=> state_reg == BS_PRECHARGING)
		else $error("precharge of idle bank skipped the precharge period");
	a_auto_read_taken: assert property (
		bankPort.opValid && bankPort.op == BO_READ && bankPort.autoPrecharge |=> state_reg == BS_READ_AUTO)
		else $error("read with auto precharge not taken");
endmodule

// [hw/dbcl_legality.sv]
`timescale 1ns/1ps
module dbcl_legality import dbcl_pkg::*; (
	input  wire logic                                   clk_sys,
	input  wire logic                                   sys_rst,
	input  wire logic                                   linkClk,
	input  wire logic                                   cke,
	input  wire logic                                   csN,
	input  wire logic [3:0]                             cmdCode,
	input  wire logic [BANK_W-1:0]                      bankSel,
	input  wire logic                                   autoPrecharge,
	input  wire logic [7:0]                             modeAddr,
	output logic [NUM_BANKS-1:0][3:0]                   bankStates,
	output dbcl_dev_state_t                             devState,
	output logic                                        cmdAccepted,
	output logic                                        cmdRejected
);
	localparam int PIN_W = 1 + 1 + 4 + BANK_W + 1 + 8;

	logic [PIN_W-1:0]     pinSync1_reg;
	logic [PIN_W-1:0]     pinSync2_reg;
	logic                 ckSync1_reg;
	logic                 ckSync2_reg;
	logic                 ckSync3_reg;
	logic                 linkRise;
	logic                 ckeNow;
	logic                 csNowN;
	logic [3:0]           cmdBits;
	dbcl_cmd_t            cmdNow;
	logic [BANK_W-1:0]    bankNow;
	logic                 autoNow;
	logic [7:0]           addrNow;
	logic                 ckePrev_reg;
	logic [TMR_W-1:0]     exitCnt_reg;
	logic                 taken;
	logic                 legal;
	logic                 accept;
	logic                 isResetAddr;
	dbcl_bank_state_t     tgtState;
	dbcl_bank_state_t     stArr [NUM_BANKS];
	logic                 anyBurst;
	logic                 anyRdBurst;
	logic                 anyWrBurst;
	logic                 anyHold;
	logic                 allIdle;
	logic                 allPreOk;
	logic                 allModeRdOk;
	dbcl_bank_op_t        bankOp;
	logic [NUM_BANKS-1:0] opRaw;
	logic [NUM_BANKS-1:0] opMask;
	logic [NUM_BANKS-1:0] tgtMask;
	dbcl_dev_state_t      devState_reg;
	logic [TMR_W-1:0]     devTimer_reg;
	logic [TMR_W-1:0]     initCnt_reg;
	logic [BANK_W-1:0]    lastBurst_reg;
	logic                 cmdAccepted_reg;
	logic                 cmdRejected_reg;

	////////////////////////////////////////////////////////////////////////////////
	// pins and the link clock come from the controller's domain
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pinSync1_reg <= '0;
			pinSync2_reg <= '0;
		end else begin
			pinSync1_reg <= {cke, csN, cmdCode, bankSel, autoPrecharge, modeAddr};
			pinSync2_reg <= pinSync1_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ckSync1_reg <= 1'b0;
			ckSync2_reg <= 1'b0;
			ckSync3_reg <= 1'b0;
		end else begin
			ckSync1_reg <= linkClk;
			ckSync2_reg <= ckSync1_reg;
			ckSync3_reg <= ckSync2_reg;
		end
	end

	assign linkRise = ckSync2_reg & ~ckSync3_reg;
	assign {ckeNow, csNowN, cmdBits, bankNow, autoNow, addrNow} = pinSync2_reg;
	assign cmdNow = dbcl_cmd_t'(cmdBits);
	assign isResetAddr = addrNow == RESET_MODE_ADDR;

	// clock enable history and exit holdoff
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ckePrev_reg <= 1'b0;
		end else if (linkRise) begin
			ckePrev_reg <= ckeNow;
		end
	end

	// reloaded on every low sample, so it runs from the last low edge on
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			exitCnt_reg <= '0;
		end else if (linkRise && !ckeNow) begin
			exitCnt_reg <= EXIT_CYC;
		end else if (exitCnt_reg != '0) begin
			exitCnt_reg <= exitCnt_reg - TMR_ONE;
		end
	end

	assign taken = linkRise && ckeNow && ckePrev_reg && exitCnt_reg == '0 && !csNowN;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		anyBurst = 1'b0;
		anyRdBurst = 1'b0;
		anyWrBurst = 1'b0;
		anyHold = 1'b0;
		allIdle = 1'b1;
		allPreOk = 1'b1;
		allModeRdOk = 1'b1;
		for (int b = 0; b < NUM_BANKS; b++) begin
			anyBurst = anyBurst | is_burst(stArr[b]);
			anyRdBurst = anyRdBurst | stArr[b] == BS_READING | stArr[b] == BS_READ_AUTO;
			anyWrBurst = anyWrBurst | stArr[b] == BS_WRITING | stArr[b] == BS_WRITE_AUTO;
			anyHold = anyHold | stArr[b] == BS_REFRESHING | stArr[b] == BS_IDLE_MODE_RD
				| stArr[b] == BS_ACTIVE_MODE_RD;
			allIdle = allIdle & stArr[b] == BS_IDLE;
			allPreOk = allPreOk & (stArr[b] == BS_IDLE || stArr[b] == BS_ACTIVE || is_plain_burst(stArr[b]));
			allModeRdOk = allModeRdOk & (stArr[b] == BS_IDLE || stArr[b] == BS_ACTIVE
				|| stArr[b] == BS_ACTIVATING || stArr[b] == BS_PRECHARGING);
		end
	end

	assign tgtState = stArr[bankNow];
	assign tgtMask = NUM_BANKS'(1) << bankNow;

	// anything not listed below stays illegal and is ignored
	always_comb begin
		legal = 1'b0;
		bankOp = BO_ACTIVATE;
		opRaw = '0;
		case (devState_reg)
			DS_POWER_ON: begin
				legal = cmdNow == CMD_MODE_WRITE && isResetAddr;
			end
			DS_RESETTING: begin
				legal = cmdNow == CMD_MODE_READ;
			end
			DS_READY: begin
				if (!anyHold) begin
					case (cmdNow)
						CMD_ACTIVATE: begin
							legal = tgtState == BS_IDLE;
							bankOp = BO_ACTIVATE;
							opRaw = tgtMask;
						end
						CMD_READ: begin
							legal = (tgtState == BS_ACTIVE || tgtState == BS_READING) && !anyWrBurst;
							bankOp = BO_READ;
							opRaw = tgtMask;
						end
						CMD_WRITE: begin
							legal = (tgtState == BS_ACTIVE || tgtState == BS_WRITING) && !anyRdBurst;
							bankOp = BO_WRITE;
							opRaw = tgtMask;
						end
						CMD_PRECHARGE: begin
							legal = tgtState == BS_IDLE || tgtState == BS_ACTIVE || is_plain_burst(tgtState);
							bankOp = BO_PRECHARGE;
							opRaw = tgtMask;
						end
						CMD_PRECHARGE_ALL: begin
							legal = allPreOk;
							bankOp = BO_PRECHARGE;
							opRaw = '1;
						end
						CMD_REFRESH_BANK: begin
							legal = tgtState == BS_IDLE && !anyBurst;
							bankOp = BO_REFRESH;
							opRaw = tgtMask;
						end
						CMD_REFRESH_ALL: legal = allIdle && !anyBurst;
						CMD_MODE_WRITE: legal = allIdle && !anyBurst;
						CMD_MODE_READ: begin
							legal = allModeRdOk;
							bankOp = BO_MODE_READ;
							opRaw = '1;
						end
						CMD_BURST_STOP: begin
							legal = is_plain_burst(stArr[lastBurst_reg]);
							bankOp = BO_STOP;
							opRaw = NUM_BANKS'(1) << lastBurst_reg;
						end
						default: legal = 1'b0;
					endcase
				end
			end
			default: legal = 1'b0;
		endcase
	end

	assign accept = taken && legal;
	assign opMask = accept ? opRaw : '0;

	////////////////////////////////////////////////////////////////////////////////
	dbcl_bank_if bankIf [NUM_BANKS] ();

	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		assign bankIf[b].opValid = opMask[b];
		assign bankIf[b].op = bankOp;
		assign bankIf[b].autoPrecharge = autoNow;
		assign bankIf[b].linkTick = linkRise;
		assign stArr[b] = bankIf[b].state;
		assign bankStates[b] = bankIf[b].state;
		dbcl_bank u_bank (
			.clk_sys  (clk_sys),
			.sys_rst  (sys_rst),
			.bankPort (bankIf[b])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// device-wide busy states sit beside the per-bank states
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			devState_reg <= DS_POWER_ON;
			devTimer_reg <= '0;
		end else if (accept) begin
			case (cmdNow)
				CMD_REFRESH_ALL: begin
					devState_reg <= DS_REFRESH_ALL;
					devTimer_reg <= RFCAB_CYC - TMR_ONE;
				end
				CMD_MODE_WRITE: begin
					if (isResetAddr) begin
						devState_reg <= DS_RESETTING;
					end else begin
						devState_reg <= DS_MODE_WRITING;
						devTimer_reg <= MWR_CYC - TMR_ONE;
					end
				end
				CMD_PRECHARGE_ALL: begin
					devState_reg <= DS_PRECHARGE_ALL;
					devTimer_reg <= RP_CYC - TMR_ONE;
				end
				CMD_MODE_READ: begin
					if (devState_reg == DS_RESETTING) begin
						devState_reg <= DS_RESET_MODE_RD;
						devTimer_reg <= MRD_CYC - TMR_ONE;
					end
				end
				default: devState_reg <= devState_reg;
			endcase
		end else if (devTimer_reg != '0) begin
			devTimer_reg <= devTimer_reg - TMR_ONE;
		end else begin
			case (devState_reg)
				DS_REFRESH_ALL:   devState_reg <= DS_READY;
				DS_MODE_WRITING:  devState_reg <= DS_READY;
				DS_PRECHARGE_ALL: devState_reg <= DS_READY;
				DS_RESET_MODE_RD: devState_reg <= DS_RESETTING;
				DS_RESETTING: begin
					if (initCnt_reg == '0)
						devState_reg <= DS_READY;
				end
				default: devState_reg <= devState_reg;
			endcase
		end
	end

	// auto-initialization keeps running under a mode read
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			initCnt_reg <= '0;
		end else if (accept && cmdNow == CMD_MODE_WRITE && isResetAddr) begin
			initCnt_reg <= INIT_CYC - TMR_ONE;
		end else if (initCnt_reg != '0) begin
			initCnt_reg <= initCnt_reg - TMR_ONE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lastBurst_reg <= '0;
		end else if (accept && (cmdNow == CMD_READ || cmdNow == CMD_WRITE)) begin
			lastBurst_reg <= bankNow;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cmdAccepted_reg <= 1'b0;
			cmdRejected_reg <= 1'b0;
		end else begin
			cmdAccepted_reg <= accept;
			cmdRejected_reg <= taken && cmdNow != CMD_NOP && !legal;
		end
	end

	assign devState = devState_reg;
	assign cmdAccepted = cmdAccepted_reg;
	assign cmdRejected = cmdRejected_reg;

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	localparam int RfcAbLim = 8;
	localparam int MwrLim = 4;

	sequence s_reset_cmd;
		accept && cmdNow == CMD_MODE_WRITE && isResetAddr;
	endsequence

	sequence s_prea_cmd;
		accept && cmdNow == CMD_PRECHARGE_ALL;
	endsequence

	a_reset_decode: assert property (s_reset_cmd |=> devState_reg == DS_RESETTING)
		else $error("reset via mode write not decoded");
	a_refresh_all_span: assert property (
		$rose(devState_reg == DS_REFRESH_ALL) |-> (devState_reg == DS_REFRESH_ALL) [*4]
		##1 devState_reg == DS_READY)
		else $error("all-bank refresh did not last its refresh time");
	a_mode_write_span: assert property (
		$rose(devState_reg == DS_MODE_WRITING) |-> ##[1:MwrLim] devState_reg == DS_READY)
		else $error("mode write busy state did not end");
	a_prea_span: assert property (
		s_prea_cmd |=> devState_reg == DS_PRECHARGE_ALL && bankStates[0] == BS_PRECHARGING
		##1 devState_reg == DS_READY)
		else $error("precharge-all did not end after its period");
	a_busy_refused: assert property (
		taken && cmdNow != CMD_NOP && devState_reg != DS_READY && devState_reg != DS_POWER_ON
		&& !(devState_reg == DS_RESETTING && cmdNow == CMD_MODE_READ) |=> cmdRejected && !cmdAccepted)
		else $error("command accepted while device busy");
	a_enable_gate: assert property (linkRise && !ckePrev_reg |=> !cmdAccepted)
		else $error("command accepted without clock enable history");
	a_stop_latest: assert property (
		accept && cmdNow == CMD_BURST_STOP |=> bankStates[$past(lastBurst_reg)] == BS_ACTIVE)
		else $error("terminate missed the most recent burst");
	a_reset_mode_read: assert property (
		accept && cmdNow == CMD_MODE_READ && devState_reg == DS_RESETTING
		|=> devState_reg == DS_RESET_MODE_RD ##[1:RfcAbLim] devState_reg == DS_RESETTING)
		else $error("mode read during resetting did not return");
endmodule

// [dv/dbcl_ctrl_model.sv]
`timescale 1ns/1ps
module dbcl_ctrl_model (
	input  wire logic       clk_sys,
	input  wire logic       cmdAccepted,
	input  wire logic       cmdRejected,
	output logic            linkClk,
	output logic            cke,
	output logic            csN,
	output logic [3:0]      cmdCode,
	output logic [2:0]      bankSel,
	output logic            autoPrecharge,
	output logic [7:0]      modeAddr
);
	initial begin
		linkClk = 1'b0;
		cke = 1'b1;
		csN = 1'b1;
		cmdCode = 4'h0;
		bankSel = 3'h0;
		autoPrecharge = 1'b0;
		modeAddr = 8'h00;
	end

	////////////////////////////////////////////////////////////////
	// one 320 ns link period per command, entered at a clock edge; link clock stands still between commands
	task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic ap, input logic [7:0] a,
		input logic ce, output logic [1:0] res);
		res = 2'b00;
		cke <= ce;
		csN <= (c == 4'h0);
		cmdCode <= c;
		bankSel <= b;
		autoPrecharge <= ap;
		modeAddr <= a;
		// lines move with the link rise; both pass the same two flops
		linkClk <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			if (cmdAccepted === 1'b1) res[0] = 1'b1;
			if (cmdRejected === 1'b1) res[1] = 1'b1;
			if (i == 3) begin
				linkClk <= 1'b0;
				// released lines must not keep looking like the last command
				csN <= 1'b1;
				cmdCode <= ~cmdCode;
				bankSel <= ~bankSel;
				modeAddr <= ~modeAddr;
			end
		end
	endtask
endmodule

// [dv/dram_bank_command_legality_bench.sv]
`timescale 1ns/1ps
module dram_bank_command_legality_bench;
	import dbcl_pkg::*;
	logic                       clk_sys;
	logic                       sys_rst;
	logic                       linkClk, cke, csN, autoPrecharge, cmdAccepted, cmdRejected;
	logic [3:0]                 cmdCode;
	logic [2:0]                 bankSel;
	logic [7:0]                 modeAddr;
	logic [NUM_BANKS-1:0][3:0]  bankStates, snapB;
	dbcl_dev_state_t            devState, snapD;
	int                         failCount = 0;
	int                         totalChecks = 0;
	int                         cycles = 0;

	dbcl_legality dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .linkClk(linkClk), .cke(cke), .csN(csN),
		.cmdCode(cmdCode), .bankSel(bankSel), .autoPrecharge(autoPrecharge), .modeAddr(modeAddr),
		.bankStates(bankStates), .devState(devState), .cmdAccepted(cmdAccepted), .cmdRejected(cmdRejected));
	dbcl_ctrl_model ctrl_u (.clk_sys(clk_sys), .cmdAccepted(cmdAccepted), .cmdRejected(cmdRejected),
		.linkClk(linkClk), .cke(cke), .csN(csN), .cmdCode(cmdCode), .bankSel(bankSel),
		.autoPrecharge(autoPrecharge), .modeAddr(modeAddr));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// states short-lived as precharge only show in the answer cycle
	always @(posedge clk_sys) begin
		if (cmdAccepted === 1'b1 || cmdRejected === 1'b1) begin
			snapB <= bankStates;
			snapD <= devState;
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic endOfTest();
		$display("checks %0d mismatches %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			failCount++;
			endOfTest();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			failCount++;
		end
	endtask

	task automatic go(input logic [3:0] c, input logic [2:0] b, input logic ap, input logic [7:0] a,
		input logic ce, input logic [1:0] exp);
		logic [1:0] r;
		ctrl_u.issue(c, b, ap, a, ce, r);
		check("answer", {30'h0, r}, {30'h0, exp});
	endtask

	////////////////////////////////////////////////////////////////
	task automatic testInit();
		int n;
		check("banks", bankStates, 32'h0);
		check("dev", devState, DS_POWER_ON);
		// first rise only primes the clock-enable history
		go(CMD_NOP, 3'h0, 1'b0, 8'h00, 1'b1, 2'b00);
		go(CMD_ACTIVATE, 3'h0, 1'b0, 8'h00, 1'b1, 2'b10);
		go(CMD_MODE_WRITE, 3'h0, 1'b0, RESET_MODE_ADDR, 1'b1, 2'b01);
		check("dev", snapD, DS_RESETTING);
		go(CMD_MODE_READ, 3'h0, 1'b0, 8'h00, 1'b1, 2'b01);
		check("dev", snapD, DS_RESET_MODE_RD);
		go(CMD_ACTIVATE, 3'h0, 1'b0, 8'h00, 1'b1, 2'b10);
		for (n = 0; n < 400 && devState !== DS_READY; n++) @(posedge clk_sys);
		check("dev", devState, DS_READY);
	endtask

	task automatic testBanks();
		go(CMD_ACTIVATE, 3'h0, 1'b0, 8'h00, 1'b1, 2'b01);
		check("b0", snapB[0], BS_ACTIVATING);
		check("b0", bankStates[0], BS_ACTIVE);
		go(CMD_ACTIVATE, 3'h1, 1'b0, 8'h00, 1'b1, 2'b01);
		go(CMD_READ, 3'h1, 1'b1, 8'h00, 1'b1, 2'b01);
		check("b1", snapB[1], BS_READ_AUTO);
		go(CMD_READ, 3'h0, 1'b0, 8'h00, 1'b1, 2'b01);
		check("b0", snapB[0], BS_READING);
		go(CMD_REFRESH_BANK, 3'h5, 1'b0, 8'h00, 1'b1, 2'b10);
		go(CMD_BURST_STOP, 3'h5, 1'b0, 8'h00, 1'b1, 2'b01);
		check("b0", snapB[0], BS_ACTIVE);
		check("b1", snapB[1], BS_READ_AUTO);
		go(CMD_WRITE, 3'h0, 1'b0, 8'h00, 1'b1, 2'b10);
		repeat (3) go(CMD_NOP, 3'h0, 1'b0, 8'h00, 1'b1, 2'b00);
		check("b1", bankStates[1], BS_IDLE);
		go(CMD_MODE_READ, 3'h0, 1'b0, 8'h00, 1'b1, 2'b01);
		check("b0", snapB[0], BS_ACTIVE_MODE_RD);
		check("b1", snapB[1], BS_IDLE_MODE_RD);
		check("b0", bankStates[0], BS_ACTIVE);
	endtask

	task automatic testPrecharge();
		go(CMD_PRECHARGE, 3'h2, 1'b0, 8'h00, 1'b1, 2'b01);
		check("b2", snapB[2], BS_PRECHARGING);
		go(CMD_PRECHARGE_ALL, 3'h0, 1'b0, 8'h00, 1'b1, 2'b01);
		check("dev", snapD, DS_PRECHARGE_ALL);
		check("b0", snapB[0], BS_PRECHARGING);
		check("banks", bankStates, 32'h0);
		check("dev", devState, DS_READY);
	endtask

	task automatic testRefresh();
		go(CMD_REFRESH_BANK, 3'h3, 1'b0, 8'h00, 1'b1, 2'b01);
		check("b3", snapB[3], BS_REFRESHING);
		check("b3", bankStates[3], BS_IDLE);
		go(CMD_REFRESH_ALL, 3'h0, 1'b0, 8'h00, 1'b1, 2'b01);
		check("dev", snapD, DS_REFRESH_ALL);
		check("dev", devState, DS_READY);
		go(CMD_MODE_WRITE, 3'h0, 1'b0, 8'h01, 1'b1, 2'b01);
		check("dev", snapD, DS_MODE_WRITING);
		check("dev", devState, DS_READY);
		go(CMD_ACTIVATE, 3'h4, 1'b0, 8'h00, 1'b1, 2'b01);
		go(CMD_WRITE, 3'h4, 1'b0, 8'h00, 1'b1, 2'b01);
		go(CMD_REFRESH_ALL, 3'h0, 1'b0, 8'h00, 1'b1, 2'b10);
		go(CMD_READ, 3'h4, 1'b0, 8'h00, 1'b1, 2'b10);
		go(CMD_BURST_STOP, 3'h0, 1'b0, 8'h00, 1'b1, 2'b01);
		check("b4", snapB[4], BS_ACTIVE);
		go(CMD_BURST_STOP, 3'h4, 1'b0, 8'h00, 1'b1, 2'b10);
	endtask

	task automatic testClockEnable();
		go(CMD_ACTIVATE, 3'h6, 1'b0, 8'h00, 1'b0, 2'b00);
		go(CMD_ACTIVATE, 3'h6, 1'b0, 8'h00, 1'b1, 2'b00);
		go(CMD_ACTIVATE, 3'h6, 1'b0, 8'h00, 1'b1, 2'b01);
	endtask

	initial begin
		sys_rst = 1'b1;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		testInit();
		testBanks();
		testPrecharge();
		testRefresh();
		testClockEnable();
		endOfTest();
	end
endmodule
